// File: rtl/monitor_pkg.sv
// constants shared by the serial port and the monitor register bank
// assumes a single 200 MHz clock domain
`default_nettype none
package monitor_pkg;
  // register pointer addresses
  localparam logic [7:0]  PTR_CONFIG     = 8'h00;
  localparam logic [7:0]  PTR_MASK       = 8'h06;
  localparam logic [7:0]  PTR_THRESHOLD  = 8'h07;
  localparam logic [7:0]  PTR_MAKER      = 8'hfe;
  localparam logic [7:0]  PTR_DIE        = 8'hff;
  // reset values
  localparam logic [15:0] CONFIG_RESET   = 16'h4000;
  localparam logic [15:0] MASK_RESET     = 16'h0000;
  localparam logic [15:0] THRESH_RESET   = 16'h0000;
  // configuration fields
  localparam int CFG_RST  = 15;
  localparam int AVG_LO   = 9;
  localparam int BCT_LO   = 6;
  localparam int SCT_LO   = 3;
  localparam int MODE_LO  = 0;
  localparam logic [2:0]  MODE_OFF_A     = 3'h0;
  localparam logic [2:0]  MODE_OFF_B     = 3'h4;
  localparam logic [2:0]  SCT_SHORT_CODE = 3'h0;
  localparam logic [2:0]  SCT_LONG_CODE  = 3'h4;
  // mask/enable fields
  localparam int MSK_SHUNT_OVER  = 15;
  localparam int MSK_SHUNT_UNDER = 14;
  localparam int MSK_BUS_OVER    = 13;
  localparam int MSK_BUS_UNDER   = 12;
  localparam int MSK_POWER_OVER  = 11;
  localparam int MSK_READY_EN    = 10;
  localparam int MSK_FUNC_FLAG   = 4;
  localparam int MSK_DONE_FLAG   = 3;
  localparam int MSK_OVF_FLAG    = 2;
  localparam int MSK_LEVEL       = 1;
  localparam int MSK_LATCH       = 0;
  localparam logic [15:0] MASK_WR_BITS   = 16'hffe3;
  // die code fields
  localparam int DIE_PART_LO = 4;
  // timing
  localparam int CLK_PERIOD_PS    = 5000;
  localparam int SCT_SHORT_NS     = 150000;
  localparam int SCT_LONG_NS      = 1036000;
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h40;
endpackage
`default_nettype wire

// File: rtl/reg_access_if.sv
// register access path between the serial port and the register bank
// assumes both ends share clk
`default_nettype none
interface reg_access_if;
  logic [7:0]  addr;
  logic [15:0] wdata;
  logic        wr_stb;
  logic        rd_stb;
  logic [15:0] rdata;
  modport port_side (output addr, output wdata, output wr_stb, output rd_stb, input rdata);
  modport bank_side (input addr, input wdata, input wr_stb, input rd_stb, output rdata);
endinterface
`default_nettype wire

// File: rtl/serial_slave.sv
// two-wire serial slave: pointer byte, then 16-bit words msb first
// assumes scl and sda arrive asynchronously and are oversampled by clk
`default_nettype none
module serial_slave (
  input  wire logic       clk,       // system clock
  input  wire logic       rstn,      // async reset, active low
  input  wire logic [6:0] dev_addr,  // bus address of this device
  input  wire logic       scl_in,    // serial clock pin
  input  wire logic       sda_in,    // serial data pin level
  output logic            sda_o,     // data pin drive value
  output logic            sda_oe,    // data pin pulled low while high
  reg_access_if.port_side ra         // register access
);
  typedef enum logic [6:0] {
    S_IDLE = 7'h01, S_ADDR = 7'h02, S_ADDR_ACK = 7'h04, S_WR = 7'h08,
    S_WR_ACK = 7'h10, S_RD = 7'h20, S_RD_ACK = 7'h40
  } st_type;

  logic [1:0] scl_sync_ff, sda_sync_ff;
  logic       scl_d_ff, sda_d_ff;
  st_type     st_ff;
  logic [3:0] bit_ff;
  logic [7:0] shift_ff, tx_ff;
  logic [1:0] byte_ff;
  logic       rw_ff, nack_ff, lsb_next_ff, oe_ff;
  logic [7:0] ptr_ff, msb_ff;
  logic [15:0] word_ff;
  logic       rise, fall, start, stop;

  // ----------------------------------------
  // pin synchronisers and edge finding
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
      scl_d_ff    <= 1'b1;
      sda_d_ff    <= 1'b1;
    end else begin
      scl_sync_ff <= {scl_sync_ff[0], scl_in};
      sda_sync_ff <= {sda_sync_ff[0], sda_in};
      scl_d_ff    <= scl_sync_ff[1];
      sda_d_ff    <= sda_sync_ff[1];
    end
  end
  assign rise  = scl_sync_ff[1] & ~scl_d_ff;
  assign fall  = ~scl_sync_ff[1] & scl_d_ff;
  assign start = scl_sync_ff[1] & scl_d_ff & sda_d_ff & ~sda_sync_ff[1];
  assign stop  = scl_sync_ff[1] & scl_d_ff & ~sda_d_ff & sda_sync_ff[1];

  // ----------------------------------------
  // protocol state machine
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= S_IDLE;
      bit_ff <= 4'h0;
      shift_ff <= 8'h00;
      tx_ff <= 8'h00;
      byte_ff <= 2'h0;
      rw_ff <= 1'b0;
      nack_ff <= 1'b0;
      lsb_next_ff <= 1'b0;
      oe_ff <= 1'b0;
      ptr_ff <= 8'h00;
      msb_ff <= 8'h00;
    end else if (start) begin
      st_ff <= S_ADDR;
      bit_ff <= 4'h0;
      byte_ff <= 2'h0;
      oe_ff <= 1'b0;
    end else if (stop) begin
      st_ff <= S_IDLE;
      oe_ff <= 1'b0;
    end else if (rise) begin
      bit_ff <= bit_ff + 4'h1;
      if (st_ff == S_ADDR || st_ff == S_WR)
        shift_ff <= {shift_ff[6:0], sda_sync_ff[1]};
      if (st_ff == S_RD_ACK)
        nack_ff <= sda_sync_ff[1];
    end else if (fall) begin
      unique case (st_ff)
        S_IDLE: ;
        S_ADDR: if (bit_ff == 4'h8) begin
          if (shift_ff[7:1] == dev_addr) begin
            st_ff <= S_ADDR_ACK;
            rw_ff <= shift_ff[0];
            oe_ff <= 1'b1;
          end else begin
            st_ff <= S_IDLE;
          end
        end
        S_ADDR_ACK: begin
          bit_ff <= 4'h0;
          if (rw_ff) begin
            st_ff <= S_RD;
            tx_ff <= ra.rdata[15:8];
            oe_ff <= ~ra.rdata[15];
            lsb_next_ff <= 1'b1;
          end else begin
            st_ff <= S_WR;
            oe_ff <= 1'b0;
          end
        end
        S_WR: if (bit_ff == 4'h8) begin
          st_ff <= S_WR_ACK;
          oe_ff <= 1'b1;
          unique case (byte_ff)
            2'h0: ptr_ff <= shift_ff;
            2'h1: msb_ff <= shift_ff;
            default: ;
          endcase
          byte_ff <= (byte_ff == 2'h2) ? 2'h1 : byte_ff + 2'h1;
        end
        S_WR_ACK: begin
          st_ff <= S_WR;
          oe_ff <= 1'b0;
          bit_ff <= 4'h0;
        end
        S_RD: if (bit_ff == 4'h8) begin
          st_ff <= S_RD_ACK;
          oe_ff <= 1'b0;
        end else begin
          oe_ff <= ~tx_ff[3'(4'h7 - bit_ff)];
        end
        S_RD_ACK: begin
          bit_ff <= 4'h0;
          if (nack_ff) begin
            st_ff <= S_IDLE;
          end else begin
            st_ff <= S_RD;
            tx_ff <= lsb_next_ff ? word_ff[7:0] : ra.rdata[15:8];
            oe_ff <= ~(lsb_next_ff ? word_ff[7] : ra.rdata[15]);
            lsb_next_ff <= ~lsb_next_ff;
          end
        end
      endcase
    end
  end

  // word latched at the msb fetch so both bytes come from one read
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      word_ff <= 16'h0000;
    else if (ra.rd_stb)
      word_ff <= ra.rdata;
  end

  assign ra.rd_stb = fall & ((st_ff == S_ADDR_ACK & rw_ff) |
                             (st_ff == S_RD_ACK & ~nack_ff & ~lsb_next_ff));
  assign ra.wr_stb = fall & (st_ff == S_WR) & (bit_ff == 4'h8) & (byte_ff == 2'h2);
  assign ra.addr   = ptr_ff;
  assign ra.wdata  = {msb_ff, shift_ff};
  assign sda_o     = 1'b0;
  assign sda_oe    = oe_ff;
endmodule
`default_nettype wire

// File: rtl/monitor_alert_regs.sv
// register bank and alert logic of a current, voltage and power monitor
// assumes results arrive from a front end on clk with a one-cycle valid pulse
//
// Overview of operation
// - Read/write 16-bit alert threshold at pointer 07h, cleared at power-up.
// - Compare threshold with the quantity picked by the enabled alert function.
// - Read-only maker code at pointer FEh returns a fixed value.
// - Read-only die code at FFh: part code 15:4, revision 3:0.
// - Configuration: reset 15, reserved 14:12, averaging, bus time, shunt time, mode.
// - Shunt time code 100 means 1.036 ms, code 000 means 150 us.
// - Five limit functions; alert output serves only the enabled one.
// - Mask/enable layout: five enables, ready enable, reserved, three flags, level, latch.
// - Several functions enabled: only the highest enabled bit counts.
// - Level bit clear gives active-low alert, set gives active-high.
// - Ready flag cleared by non power-down config write or mask read.
`default_nettype none
module monitor_alert_regs #(
  parameter int unsigned SCT_SHORT_CYC = monitor_pkg::SCT_SHORT_NS * 1000
                                         / monitor_pkg::CLK_PERIOD_PS, // 150 us in cycles
  parameter int unsigned SCT_LONG_CYC  = monitor_pkg::SCT_LONG_NS * 1000
                                         / monitor_pkg::CLK_PERIOD_PS, // 1.036 ms in cycles
  parameter logic [15:0] MAKER_CODE    = 16'h5a5a, // arbitrary value
  parameter logic [11:0] PART_CODE     = 12'h123,  // arbitrary value
  parameter logic [3:0]  REV_CODE      = 4'h1      // arbitrary value
) (
  input  wire logic        clk,                   // 200 MHz clock
  input  wire logic        rstn,                  // async reset, active low
  input  wire logic        scl_in,                // serial clock pin
  input  wire logic        sda_in,                // serial data pin level
  output logic             sda_o,                 // data pin drive value
  output logic             sda_oe,                // data pin driven low while high
  input  wire logic [15:0] shunt_value,           // signed shunt result
  input  wire logic [15:0] bus_value,             // bus result
  input  wire logic [15:0] power_value,           // power result
  input  wire logic        result_valid,          // new result pulse
  input  wire logic        math_overflow,         // overflow with this result
  output logic             alert_out,             // alert pin level
  output logic [2:0]       sample_averaging,      // averaging code
  output logic [2:0]       bus_conversion_time,   // bus time code
  output logic [2:0]       shunt_conversion_time, // shunt time code
  output logic [2:0]       op_mode,               // operating mode code
  output logic [17:0]      shunt_conv_cycles,     // shunt time in clk cycles
  output logic             soft_reset             // reset request pulse
);
  reg_access_if ra ();

  logic [15:0] cfg_ff, mask_ff, thr_ff;
  logic        cond_ff, aff_ff, conversion_done_flag_ff, ovf_ff, shunt_ct_long_ff;
  logic        nxt_cond, nxt_aff, cfg_wr, mask_wr, thr_wr, mask_rd, latch_on, active;
  logic [4:0]  fn_en;
  logic [4:0]  fn_sel;
  logic [4:0]  fn_hit;

  serial_slave u_port (
    .clk      (clk),
    .rstn     (rstn),
    .dev_addr (monitor_pkg::DEV_ADDR_DEFAULT),
    .scl_in   (scl_in),
    .sda_in   (sda_in),
    .sda_o    (sda_o),
    .sda_oe   (sda_oe),
    .ra       (ra.port_side)
  );

  // ----------------------------------------
  // register decode
  // ----------------------------------------
  assign cfg_wr  = ra.wr_stb & (ra.addr == monitor_pkg::PTR_CONFIG);
  assign mask_wr = ra.wr_stb & (ra.addr == monitor_pkg::PTR_MASK);
  assign thr_wr  = ra.wr_stb & (ra.addr == monitor_pkg::PTR_THRESHOLD);
  assign mask_rd = ra.rd_stb & (ra.addr == monitor_pkg::PTR_MASK);
  assign soft_reset = cfg_wr & ra.wdata[monitor_pkg::CFG_RST];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      cfg_ff <= monitor_pkg::CONFIG_RESET;
    else if (soft_reset)
      cfg_ff <= monitor_pkg::CONFIG_RESET;
    else if (cfg_wr)
      cfg_ff <= {1'b0, ra.wdata[14:0]};
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      thr_ff <= monitor_pkg::THRESH_RESET;
    else if (soft_reset)
      thr_ff <= monitor_pkg::THRESH_RESET;
    else if (thr_wr)
      thr_ff <= ra.wdata;
  end

  // flag bits 4:2 are hardware owned and ignore writes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      mask_ff <= monitor_pkg::MASK_RESET;
    else if (soft_reset)
      mask_ff <= monitor_pkg::MASK_RESET;
    else if (mask_wr)
      mask_ff <= ra.wdata & monitor_pkg::MASK_WR_BITS;
  end

  always_comb begin
    unique case (ra.addr)
      monitor_pkg::PTR_CONFIG:    ra.rdata = cfg_ff;
      monitor_pkg::PTR_MASK:      ra.rdata = {mask_ff[15:5], aff_ff, conversion_done_flag_ff, ovf_ff,
                                              mask_ff[1:0]};
      monitor_pkg::PTR_THRESHOLD: ra.rdata = thr_ff;
      monitor_pkg::PTR_MAKER:     ra.rdata = MAKER_CODE;
      monitor_pkg::PTR_DIE:       ra.rdata = {PART_CODE, REV_CODE};
      default:                    ra.rdata = 16'h0000;
    endcase
  end

  // ----------------------------------------
  // configuration fields
  // ----------------------------------------
  assign sample_averaging      = cfg_ff[monitor_pkg::AVG_LO +: 3];
  assign bus_conversion_time   = cfg_ff[monitor_pkg::BCT_LO +: 3];
  assign shunt_conversion_time = cfg_ff[monitor_pkg::SCT_LO +: 3];
  assign op_mode               = cfg_ff[monitor_pkg::MODE_LO +: 3];

  // only the two documented codes are mapped; others use the long time
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      shunt_ct_long_ff <= 1'b0;
    else
      shunt_ct_long_ff <= (shunt_conversion_time != monitor_pkg::SCT_SHORT_CODE);
  end
  assign shunt_conv_cycles = shunt_ct_long_ff ? 18'(SCT_LONG_CYC)
                                              : 18'(SCT_SHORT_CYC);

  // ----------------------------------------
  // alert function select and compare
  // ----------------------------------------
  assign fn_en = mask_ff[monitor_pkg::MSK_POWER_OVER +: 5];
  assign fn_hit[4] = $signed(shunt_value) > $signed(thr_ff);
  assign fn_hit[3] = $signed(shunt_value) < $signed(thr_ff);
  assign fn_hit[2] = bus_value > thr_ff;
  assign fn_hit[1] = bus_value < thr_ff;
  assign fn_hit[0] = power_value > thr_ff;

  // one-hot of the highest enabled function
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_sel
      if (gi == 4) begin : g_top
        assign fn_sel[gi] = fn_en[gi];
      end else begin : g_low
        assign fn_sel[gi] = fn_en[gi] & ~|fn_en[4:gi+1];
      end
    end
  endgenerate

  assign latch_on = mask_ff[monitor_pkg::MSK_LATCH];
  assign nxt_cond = result_valid ? |(fn_sel & fn_hit) : cond_ff;
  // a new hit wins over the clear from a mask read
  assign nxt_aff  = latch_on ? ((aff_ff & ~mask_rd) | (result_valid & nxt_cond))
                             : nxt_cond;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cond_ff <= 1'b0;
      aff_ff  <= 1'b0;
    end else if (soft_reset) begin
      cond_ff <= 1'b0;
      aff_ff  <= 1'b0;
    end else begin
      cond_ff <= nxt_cond;
      aff_ff  <= nxt_aff;
    end
  end

  // ----------------------------------------
  // ready and overflow flags
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      conversion_done_flag_ff <= 1'b0;
    else if (result_valid)
      conversion_done_flag_ff <= 1'b1;
    else if (soft_reset || mask_rd ||
             (cfg_wr && ra.wdata[monitor_pkg::MODE_LO +: 3] != monitor_pkg::MODE_OFF_A &&
              ra.wdata[monitor_pkg::MODE_LO +: 3] != monitor_pkg::MODE_OFF_B))
      conversion_done_flag_ff <= 1'b0;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      ovf_ff <= 1'b0;
    else if (result_valid)
      ovf_ff <= math_overflow;
  end

  // ----------------------------------------
  // alert pin
  // ----------------------------------------
  assign active = aff_ff | (mask_ff[monitor_pkg::MSK_READY_EN] & conversion_done_flag_ff);
  assign alert_out = mask_ff[monitor_pkg::MSK_LEVEL] ? active : ~active;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence thr_load;
    thr_wr && !soft_reset ##1 1'b1;
  endsequence
  sequence ready_event;
    result_valid ##1 conversion_done_flag_ff;
  endsequence

  thr_update_a: assert property (thr_load |-> thr_ff == $past(ra.wdata))
    else $error("threshold did not take the written word");
  maker_read_a: assert property (ra.addr == monitor_pkg::PTR_MAKER |->
      ra.rdata == MAKER_CODE)
    else $error("maker code read wrong");
  die_read_a: assert property (ra.addr == monitor_pkg::PTR_DIE |->
      ra.rdata[15:4] == PART_CODE && ra.rdata[3:0] == REV_CODE)
    else $error("die code read wrong");
  cfg_field_a: assert property (cfg_wr && !soft_reset |=>
      op_mode == $past(ra.wdata[2:0]) && sample_averaging == $past(ra.wdata[11:9]))
    else $error("configuration fields not updated");
  ct_map_a: assert property (
      $past(shunt_conversion_time) == monitor_pkg::SCT_SHORT_CODE |->
      shunt_conv_cycles == 18'(SCT_SHORT_CYC))
    else $error("short shunt time not selected");
  over_cmp_a: assert property (result_valid && fn_sel[4] && !soft_reset &&
      $signed(shunt_value) > $signed(thr_ff) |=> cond_ff)
    else $error("shunt over limit missed");
  priority_a: assert property (result_valid && fn_en[4] && |fn_en[3:0] &&
      !soft_reset && $signed(shunt_value) <= $signed(thr_ff) |=> !cond_ff)
    else $error("lower function not masked");
  latch_hold_a: assert property (latch_on && aff_ff && !mask_rd && !soft_reset
      |=> aff_ff [*1])
    else $error("latched flag dropped");
  level_a: assert property (aff_ff && !mask_ff[monitor_pkg::MSK_LEVEL] |-> !alert_out)
    else $error("alert level wrong");
  ready_set_a: assert property (result_valid |-> ready_event)
    else $error("ready flag not set by result");
  ready_clr_a: assert property (conversion_done_flag_ff && mask_rd && !result_valid |=> !conversion_done_flag_ff)
    else $error("ready flag not cleared by read");
  reeval_a: assert property (result_valid && !soft_reset &&
      (fn_sel == 5'h00 || (fn_sel[2] && bus_value <= thr_ff)) |=> !cond_ff)
    else $error("compare not re-evaluated");
endmodule
`default_nettype wire

// File: verif/i2c_host_model.sv
// two-wire bus host model: drives scl, pulls sda low, reads the resolved line
// assumes the bench resolves sda with a pull-up; bit period 80 ns on a 5 ns clk
`default_nettype none
module i2c_host_model (
  input  wire logic clk,     // bench clock
  input  wire logic sda,     // resolved data line
  output logic      scl,     // serial clock, high outside frames
  output logic      sda_low  // high while the host pulls sda low
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // --------------------------------
  // bus phases, a quarter bit apart
  // --------------------------------
  task automatic q();
    repeat (4) @(negedge clk);
  endtask
  task automatic start();
    sda_low = 1'b0;
    q();
    scl = 1'b1;
    q();
    sda_low = 1'b1;
    q();
    scl = 1'b0;
    q();
  endtask
  task automatic stop();
    sda_low = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_low = 1'b0;
    q();
  endtask
  // data set mid low phase, sampled mid high phase
  task automatic bit_x(input logic b, output logic r);
    sda_low = ~b;
    q();
    scl = 1'b1;
    q();
    r = sda;
    q();
    scl = 1'b0;
    q();
  endtask
  // a = level sent in the ninth bit, nack = level seen there
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] r,
                      output logic nack);
    for (int i = 7; i >= 0; i--) bit_x(d[i], r[i]);
    bit_x(a, nack);
  endtask
endmodule
`default_nettype wire

// File: verif/monitor_alert_regs_tb.sv
// self-checking bench for the monitor register bank and alert logic
// assumes the two-wire host model and a pulled-up sda wire
`default_nettype none
module monitor_alert_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] WA = {monitor_pkg::DEV_ADDR_DEFAULT, 1'b0};
  logic        clk, rstn, scl, host_low, sda_o, sda_oe, alert_out, soft_reset;
  logic        result_valid, math_overflow;
  logic [15:0] shunt_value, bus_value, power_value;
  logic [2:0]  avg_f, bct_f, sct_f, mode_f;
  logic [17:0] sct_cyc;
  wire logic   sda = ~(sda_oe | host_low);
  int          err_total = 0, num_checks = 0, cyc = 0, n_soft = 0;

  monitor_alert_regs #(.SCT_SHORT_CYC(30), .SCT_LONG_CYC(200), .MAKER_CODE(16'h3c3c),
                       .PART_CODE(12'h9a5), .REV_CODE(4'h7)) dut (
    .clk(clk), .rstn(rstn), .scl_in(scl), .sda_in(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .shunt_value(shunt_value), .bus_value(bus_value), .power_value(power_value),
    .result_valid(result_valid), .math_overflow(math_overflow), .alert_out(alert_out),
    .sample_averaging(avg_f), .bus_conversion_time(bct_f), .shunt_conversion_time(sct_f),
    .op_mode(mode_f), .shunt_conv_cycles(sct_cyc), .soft_reset(soft_reset));
  i2c_host_model host (.clk(clk), .sda(sda), .scl(scl), .sda_low(host_low));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (soft_reset === 1'b1) n_soft++;
    if (cyc == 60000) begin
      err_total++;
      report_and_stop();
    end
  end
  // --------------------------------
  // checks, bus cycles, results
  // --------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string m);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t %s got %b", $time, m, got);
    end
  endtask
  task automatic wr_reg(input logic [7:0] p, input logic [15:0] v);
    logic [7:0] r;
    logic       n0, n1, n2, n3;
    host.start();
    host.xfer(WA, 1'b1, r, n0);
    host.xfer(p, 1'b1, r, n1);
    host.xfer(v[15:8], 1'b1, r, n2);
    host.xfer(v[7:0], 1'b1, r, n3);
    host.stop();
    chk_bit(n0 | n1 | n2 | n3, 1'b0, "write ack");
  endtask
  task automatic rd_chk(input logic [7:0] p, input logic [15:0] exp, input string m);
    logic [7:0]  r;
    logic [15:0] v;
    logic        n0, n1, n2, d;
    host.start();
    host.xfer(WA, 1'b1, r, n0);
    host.xfer(p, 1'b1, r, n1);
    host.start();
    host.xfer(WA | 8'h01, 1'b1, r, n2);
    host.xfer(8'hff, 1'b0, v[15:8], d);
    host.xfer(8'hff, 1'b1, v[7:0], d);
    host.stop();
    chk_bit(n0 | n1 | n2, 1'b0, "read ack");
    chk_word(v, exp, m);
  endtask
  task automatic meas(input logic [15:0] s, b, p, input logic ovf);
    @(negedge clk);
    {shunt_value, bus_value, power_value, math_overflow, result_valid} = {s, b, p, ovf, 1'b1};
    @(negedge clk);
    result_valid = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  // --------------------------------
  // scenarios
  // --------------------------------
  task automatic t_ids();
    rd_chk(monitor_pkg::PTR_THRESHOLD, 16'h0000, "thr reset");
    rd_chk(monitor_pkg::PTR_CONFIG, 16'h4000, "cfg reset");
    chk_bit(sct_cyc === 18'h1e, 1'b1, "short count");
    wr_reg(monitor_pkg::PTR_MAKER, 16'h0000);
    rd_chk(monitor_pkg::PTR_MAKER, 16'h3c3c, "maker");
    rd_chk(monitor_pkg::PTR_DIE, 16'h9a57, "die");
    rd_chk(8'h20, 16'h0000, "unmapped");
  endtask
  task automatic t_config();
    wr_reg(monitor_pkg::PTR_CONFIG, 16'h4025);
    rd_chk(monitor_pkg::PTR_CONFIG, 16'h4025, "cfg");
    chk_bit(sct_cyc === 18'hc8, 1'b1, "long count");
    wr_reg(monitor_pkg::PTR_CONFIG, 16'h4e45);
    chk_word({4'h0, avg_f, bct_f, sct_f, mode_f}, 16'h0e45, "fields");
    chk_bit(sct_cyc === 18'h1e, 1'b1, "short count");
    wr_reg(monitor_pkg::PTR_THRESHOLD, 16'hffff);
    rd_chk(monitor_pkg::PTR_THRESHOLD, 16'hffff, "thr rw");
    wr_reg(monitor_pkg::PTR_CONFIG, 16'h8000);
    chk_bit(n_soft == 1, 1'b1, "soft reset pulse");
    rd_chk(monitor_pkg::PTR_THRESHOLD, 16'h0000, "thr cleared");
  endtask
  task automatic t_func();
    logic [15:0] t, n;
    wr_reg(monitor_pkg::PTR_THRESHOLD, 16'h0064);
    for (int k = 0; k < 5; k++) begin
      wr_reg(monitor_pkg::PTR_MASK, 16'h8000 >> k);
      t = (k == 1 || k == 3) ? 16'h0063 : 16'h0065;
      n = (k == 1 || k == 3) ? 16'h0065 : 16'h0063;
      meas(k < 2 ? t : n, (k == 2 || k == 3) ? t : n, k == 4 ? t : n, 1'b0);
      chk_bit(alert_out, 1'b0, "alert on");
      meas(16'h0064, 16'h0064, 16'h0064, 1'b0);
      chk_bit(alert_out, 1'b1, "equal value");
      meas(k < 2 ? n : t, (k == 2 || k == 3) ? n : t, k == 4 ? n : t, 1'b0);
      chk_bit(alert_out, 1'b1, "other port");
    end
  endtask
  task automatic t_prio();
    wr_reg(monitor_pkg::PTR_MASK, 16'ha000);
    meas(16'hff00, 16'h0065, 16'h0000, 1'b0);
    chk_bit(alert_out, 1'b1, "lower enable ignored");
    meas(16'h0065, 16'h0000, 16'h0000, 1'b0);
    chk_bit(alert_out, 1'b0, "top enable used");
    wr_reg(monitor_pkg::PTR_MASK, 16'h8002);
    meas(16'h0063, 16'h0000, 16'h0000, 1'b0);
    chk_bit(alert_out, 1'b0, "high level idle");
    meas(16'h0065, 16'h0000, 16'h0000, 1'b0);
    chk_bit(alert_out, 1'b1, "high level active");
  endtask
  task automatic t_latch();
    wr_reg(monitor_pkg::PTR_MASK, 16'h8001);
    meas(16'h0065, 16'h0000, 16'h0000, 1'b0);
    chk_bit(alert_out, 1'b0, "latched on");
    meas(16'h0063, 16'h0000, 16'h0000, 1'b0);
    chk_bit(alert_out, 1'b0, "held");
    rd_chk(monitor_pkg::PTR_MASK, 16'h8019, "flags");
    chk_bit(alert_out, 1'b1, "freed by read");
  endtask
  task automatic t_ready();
    wr_reg(monitor_pkg::PTR_MASK, 16'h0400);
    meas(16'h0000, 16'h0000, 16'h0000, 1'b1);
    chk_bit(alert_out, 1'b0, "ready alert");
    wr_reg(monitor_pkg::PTR_CONFIG, 16'h4004);
    chk_bit(alert_out, 1'b0, "kept in power-down");
    wr_reg(monitor_pkg::PTR_CONFIG, 16'h4007);
    chk_bit(alert_out, 1'b1, "cleared by config");
    meas(16'h0000, 16'h0000, 16'h0000, 1'b1);
    rd_chk(monitor_pkg::PTR_MASK, 16'h040c, "ready and overflow");
    chk_bit(alert_out, 1'b1, "cleared by read");
    wr_reg(monitor_pkg::PTR_MASK, 16'h03fc);
    rd_chk(monitor_pkg::PTR_MASK, 16'h03e4, "flag bits not writable");
  endtask

  initial begin
    {rstn, result_valid, math_overflow} = 3'h0;
    {shunt_value, bus_value, power_value} = 48'h0;
    repeat (3) @(negedge clk);
    chk_bit(alert_out, 1'b1, "reset alert idle");
    chk_bit(sda_oe, 1'b0, "data pin released in reset");
    chk_bit(sda_o, 1'b0, "open drain drive value");
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    t_ids();
    t_config();
    t_func();
    t_prio();
    t_latch();
    t_ready();
    report_and_stop();
  end
endmodule
`default_nettype wire
